// ==== design/spsc_params.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef SPSC_PARAMS_SVH
`define SPSC_PARAMS_SVH

`define SPSC_STAT_OFS     12'h000
`define SPSC_BUF_OFS      12'h004
`define SPSC_CTRL_OFS     12'h008
`define SPSC_IRQ_STAT_OFS 12'h00c
`define SPSC_IRQ_MASK_OFS 12'h010

`define SPSC_EN_BIT   15
`define SPSC_SIDL_BIT 13
`define SPSC_ROV_BIT  6
`define SPSC_TBF_BIT  1
`define SPSC_RBF_BIT  0

`define SPSC_CTRL_MODE16_BIT 0
`define SPSC_CTRL_CKP_BIT    1
`define SPSC_CTRL_MASTER_BIT 2
`define SPSC_CTRL_SSEN_BIT   3
`define SPSC_CTRL_IDLE_BIT   4

`define SPSC_IRQ_RX_BIT  0
`define SPSC_IRQ_TX_BIT  1
`define SPSC_IRQ_ROV_BIT 2

`define SPSC_STAT_RESET 16'h0000
`define SPSC_CTRL_RESET 16'h0000
`define SPSC_IRQ_RESET  3'h0

`define SPSC_SCK_HALF_NS  64
`define SPSC_CLK_NS       4
`define SPSC_SCK_HALF_CYC (`SPSC_SCK_HALF_NS / `SPSC_CLK_NS)

`endif

// ==== design/spsc_pkg.sv ====
// Types shared by the serial port status and control block
package spsc_pkg;

	typedef enum logic [1:0] {
		SPSC_IDLE,
		SPSC_SHIFT,
		SPSC_DONE
	} spsc_phase_e;

	typedef struct packed {
		logic        sel;
		logic        write;
		logic [11:0] addr;
	} spsc_req_s;

	typedef struct packed {
		logic sck;
		logic sdo;
		logic sck_oe;
		logic sdo_oe;
	} spsc_pins_s;

	typedef struct packed {
		logic        en;
		logic        sidl;
		logic        rov;
		logic        tbf;
		logic        rbf;
		logic [4:0]  ctrl;
		logic [2:0]  irq_stat;
		logic [2:0]  irq_mask;
		logic [15:0] txb;
		logic [15:0] rxb;
		logic [15:0] sr;
		logic [4:0]  bits;
		logic [4:0]  div;
		spsc_phase_e phase;
		spsc_req_s   req;
		logic [31:0] hrdata;
		logic        irq;
		spsc_pins_s  pins;
		logic [2:0]  sck_sync;
		logic [1:0]  sdi_sync;
		logic [2:0]  ss_sync;
	} spsc_state_s;

endpackage : spsc_pkg

// ==== design/spsc_core.sv ====
// Serial port status/control block with AHB-Lite register slave
`timescale 1ns/1ps
`include "spsc_params.svh"

// Functional notes
// - Enable bit turns module on, claims pins
// - Stop-in-idle halts module during device idle
// - Unread receive word: set overflow, drop new
// - Buffer write loads transmit buffer, sets full
// - Move to shift register clears transmit full
// - Reception done: load receive buffer, set full
// - Buffer read returns receive data, clears full
module spsc_core (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Device state
	input  wire logic        device_idle,
	// Serial pins
	input  wire logic        serial_clock_pin_in,
	output logic             serial_clock_pin_out,
	output logic             serial_clock_pin_oe,
	output logic             serial_data_out_pin,
	output logic             serial_data_out_pin_oe,
	input  wire logic        serial_data_in_pin,
	input  wire logic        slave_select_pin_n,
	// Interrupt
	output logic             irq
);

	spsc_pkg::spsc_state_s st_reg;
	spsc_pkg::spsc_state_s st_next;

	logic        active;
	logic        mode16;
	logic        master;
	logic        sck_rise;
	logic        sck_fall;
	logic        ss_low;
	logic        wr_stb;
	logic        rd_buf;
	logic        sample_edge;
	logic        shift_edge;
	logic [4:0]  word_bits;
	logic [15:0] wdat;
	logic [15:0] stat_word;

	// Stop-in-idle gates all link activity but keeps registers
	assign active = st_reg.en && !(st_reg.sidl && device_idle);
	assign mode16 = st_reg.ctrl[`SPSC_CTRL_MODE16_BIT];
	assign master = st_reg.ctrl[`SPSC_CTRL_MASTER_BIT];
	assign word_bits = mode16 ? 5'd16 : 5'd8;
	assign wdat = hwdata[15:0];
	// Sync stage 0 is read only by stage 1
	assign sck_rise = st_reg.sck_sync[1] && !st_reg.sck_sync[2];
	assign sck_fall = !st_reg.sck_sync[1] && st_reg.sck_sync[2];
	assign ss_low = !st_reg.ss_sync[1] ||
		!st_reg.ctrl[`SPSC_CTRL_SSEN_BIT];
	assign wr_stb = st_reg.req.sel && st_reg.req.write;
	assign rd_buf = hsel && hready && htrans[1] && !hwrite &&
		(haddr[11:0] == `SPSC_BUF_OFS);

	always_comb begin
		stat_word = 16'h0000;
		stat_word[`SPSC_EN_BIT] = st_reg.en;
		stat_word[`SPSC_SIDL_BIT] = st_reg.sidl;
		stat_word[`SPSC_ROV_BIT] = st_reg.rov;
		stat_word[`SPSC_TBF_BIT] = st_reg.tbf;
		stat_word[`SPSC_RBF_BIT] = st_reg.rbf;
	end

	// Sample/shift edges: master owns its clock, slave follows the pin
	always_comb begin
		if (master) begin
			sample_edge = st_reg.phase == spsc_pkg::SPSC_SHIFT &&
				st_reg.div == 5'd0 &&
				(st_reg.pins.sck ^ st_reg.ctrl[`SPSC_CTRL_CKP_BIT]) == 1'b0;
			shift_edge = st_reg.phase == spsc_pkg::SPSC_SHIFT &&
				st_reg.div == 5'd0 &&
				(st_reg.pins.sck ^ st_reg.ctrl[`SPSC_CTRL_CKP_BIT]) == 1'b1;
		end else begin
			sample_edge = ss_low && (st_reg.ctrl[`SPSC_CTRL_CKP_BIT] ?
				sck_fall : sck_rise);
			shift_edge = ss_low && (st_reg.ctrl[`SPSC_CTRL_CKP_BIT] ?
				sck_rise : sck_fall);
		end
	end

	always_comb begin
		st_next = st_reg;
		st_next.sck_sync = {st_reg.sck_sync[1:0], serial_clock_pin_in};
		st_next.sdi_sync = {st_reg.sdi_sync[0], serial_data_in_pin};
		st_next.ss_sync = {st_reg.ss_sync[1:0], slave_select_pin_n};

		// Address phase capture
		if (hready) begin
			st_next.req.sel = hsel && htrans[1];
			st_next.req.write = hwrite;
			st_next.req.addr = haddr[11:0];
		end

		// Read data is prepared at the address phase
		if (hsel && hready && htrans[1] && !hwrite) begin
			if (haddr[11:0] == `SPSC_STAT_OFS) begin
				st_next.hrdata = {16'h0000, stat_word};
			end else if (haddr[11:0] == `SPSC_BUF_OFS) begin
				st_next.hrdata = {16'h0000, st_reg.rxb};
			end else if (haddr[11:0] == `SPSC_CTRL_OFS) begin
				st_next.hrdata = {27'h000_0000, st_reg.ctrl};
			end else if (haddr[11:0] == `SPSC_IRQ_STAT_OFS) begin
				st_next.hrdata = {29'h0000_0000, st_reg.irq_stat};
			end else if (haddr[11:0] == `SPSC_IRQ_MASK_OFS) begin
				st_next.hrdata = {29'h0000_0000, st_reg.irq_mask};
			end else begin
				st_next.hrdata = 32'h0000_0000;
			end
		end

		// Reading the buffer frees it for the next word
		if (rd_buf) begin
			st_next.rbf = 1'b0;
		end

		// Register writes in the data phase
		if (wr_stb) begin
			if (st_reg.req.addr == `SPSC_STAT_OFS) begin
				st_next.en = wdat[`SPSC_EN_BIT];
				st_next.sidl = wdat[`SPSC_SIDL_BIT];
				if (!wdat[`SPSC_ROV_BIT]) begin
					st_next.rov = 1'b0;
				end
			end else if (st_reg.req.addr == `SPSC_BUF_OFS) begin
				st_next.txb = wdat;
				st_next.tbf = 1'b1;
			end else if (st_reg.req.addr == `SPSC_CTRL_OFS) begin
				st_next.ctrl = wdat[4:0];
			end else if (st_reg.req.addr == `SPSC_IRQ_STAT_OFS) begin
				st_next.irq_stat = st_reg.irq_stat & ~wdat[2:0];
			end else if (st_reg.req.addr == `SPSC_IRQ_MASK_OFS) begin
				st_next.irq_mask = wdat[2:0];
			end
		end

		// Link engine
		if (!st_reg.en) begin
			st_next.phase = spsc_pkg::SPSC_IDLE;
			st_next.bits = 5'd0;
			st_next.pins.sck = st_reg.ctrl[`SPSC_CTRL_CKP_BIT];
		end else if (active) begin
			case (st_reg.phase)
				spsc_pkg::SPSC_IDLE: begin
					st_next.pins.sck = st_reg.ctrl[`SPSC_CTRL_CKP_BIT];
					if (st_reg.tbf && (master || ss_low)) begin
						st_next.sr = st_reg.txb;
						st_next.tbf = wr_stb &&
							st_reg.req.addr == `SPSC_BUF_OFS;
						st_next.bits = 5'd0;
						st_next.div = 5'(`SPSC_SCK_HALF_CYC - 1);
						st_next.phase = spsc_pkg::SPSC_SHIFT;
						st_next.irq_stat[`SPSC_IRQ_TX_BIT] = 1'b1;
						st_next.pins.sdo = mode16 ? st_reg.txb[15] :
							st_reg.txb[7];
					end
				end
				spsc_pkg::SPSC_SHIFT: begin
					if (master) begin
						st_next.div = (st_reg.div == 5'd0) ?
							5'(`SPSC_SCK_HALF_CYC - 1) : st_reg.div - 5'd1;
						if (st_reg.div == 5'd0) begin
							st_next.pins.sck = !st_reg.pins.sck;
						end
					end
					if (sample_edge) begin
						st_next.sr = {st_reg.sr[14:0], st_reg.sdi_sync[1]};
						st_next.bits = st_reg.bits + 5'd1;
						if (st_reg.bits + 5'd1 == word_bits) begin
							st_next.phase = spsc_pkg::SPSC_DONE;
						end
					end else if (shift_edge && st_reg.bits != 5'd0) begin
						st_next.pins.sdo = mode16 ? st_reg.sr[15] :
							st_reg.sr[7];
					end
				end
				spsc_pkg::SPSC_DONE: begin
					st_next.pins.sck = st_reg.ctrl[`SPSC_CTRL_CKP_BIT];
					st_next.phase = spsc_pkg::SPSC_IDLE;
					// Unread word: the new one is dropped
					if (st_reg.rbf && !rd_buf) begin
						st_next.rov = 1'b1;
						st_next.irq_stat[`SPSC_IRQ_ROV_BIT] = 1'b1;
					end else begin
						st_next.rxb = mode16 ? st_reg.sr :
							{8'h00, st_reg.sr[7:0]};
						st_next.rbf = 1'b1;
						st_next.irq_stat[`SPSC_IRQ_RX_BIT] = 1'b1;
					end
				end
				default: st_next.phase = spsc_pkg::SPSC_IDLE;
			endcase
		end

		st_next.pins.sck_oe = st_reg.en && master;
		st_next.pins.sdo_oe = st_reg.en && (master || ss_low);
		st_next.irq = |(st_next.irq_stat & st_next.irq_mask);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= '0;
			st_reg.ss_sync <= 3'b111;
		end else begin
			st_reg <= st_next;
		end
	end

	assign hrdata = st_reg.hrdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign serial_clock_pin_out = st_reg.pins.sck;
	assign serial_clock_pin_oe = st_reg.pins.sck_oe;
	assign serial_data_out_pin = st_reg.pins.sdo;
	assign serial_data_out_pin_oe = st_reg.pins.sdo_oe;
	assign irq = st_reg.irq;

endmodule : spsc_core

// ==== bench/spsc_core_sva.sv ====
// Port-level assertion checker for the serial port status block
`timescale 1ns/1ps
module spsc_core_sva (
	// Clock, reset and bus
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Link side
	input wire logic        device_idle,
	input wire logic        serial_clock_pin_out,
	input wire logic        serial_clock_pin_oe,
	input wire logic        serial_data_out_pin_oe
);
	logic        dv, dw, en, sl, ms;
	logic [11:0] da;
	// Data-phase tracker plus shadow of written control bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{dv, dw, en, sl, ms} <= '0;
			da <= '0;
		end else begin
			dv <= hsel && hready && htrans[1];
			dw <= hwrite;
			da <= haddr[11:0];
			if (dv && dw && da == 12'h000) begin
				en <= hwdata[15];
				sl <= hwdata[13];
			end
			if (dv && dw && da == 12'h008)
				ms <= hwdata[2];
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_okay; hreadyout && !hresp; endproperty
	a_okay: assert property (p_okay) else $error("bus stall or error");
	property p_sck_off; !en && !$past(en) && !$past(en, 2) |-> ##1 !serial_clock_pin_oe; endproperty
	a_sck_off: assert property (p_sck_off) else $error("clock pin kept");
	property p_sdo_off; !en && !$past(en) && !$past(en, 2) |-> ##1 !serial_data_out_pin_oe; endproperty
	a_sdo_off: assert property (p_sdo_off) else $error("data pin kept");
	property p_halt; en && sl && device_idle && $past(device_idle) |-> $stable(serial_clock_pin_out); endproperty
	a_halt: assert property (p_halt) else $error("clock moved in idle");
	property p_tbf; dv && dw && da == 12'h004 && !en ##2 dv && !dw && da == 12'h000 |-> hrdata[1]; endproperty
	a_tbf: assert property (p_tbf) else $error("tx full not set");
	property p_start; dv && dw && da == 12'h004 && en && ms && !device_idle |-> ##[1:40] $changed(serial_clock_pin_out); endproperty
	a_start: assert property (p_start) else $error("shift never began");
	property p_rbf; dv && !dw && da == 12'h004 ##2 dv && !dw && da == 12'h000 |-> !hrdata[0]; endproperty
	a_rbf: assert property (p_rbf) else $error("rx full kept");
	property p_rsv; dv && !dw && da == 12'h000 |-> hrdata[31:16] == 16'h0000 && !hrdata[14] && hrdata[12:7] == 6'h00 && hrdata[5:2] == 4'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("unused bit set");
endmodule : spsc_core_sva
bind spsc_core spsc_core_sva u_sva (.*);

// ==== bench/spsc_far_end.sv ====
// Far-end echo device for the serial link
`timescale 1ns/1ps
module spsc_far_end (
	// Link pins
	input  wire logic sck_oe,
	input  wire logic sdo,
	output logic      sdi
);
	// Undriven line never shows a stale bit
	assign sdi = sck_oe ? sdo : ~sdo;
endmodule : spsc_far_end

// ==== bench/serial_port_status_control_tb_top.sv ====
// Self-checking bench for the serial port status block
`timescale 1ns/1ps
module serial_port_status_control_tb_top;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
	logic        device_idle, serial_clock_pin_in, serial_clock_pin_out;
	logic        serial_clock_pin_oe, serial_data_out_pin, slave_select_pin_n;
	logic        serial_data_out_pin_oe, serial_data_in_pin;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, r;
	int          error_cnt, n_checks, cyc;
	assign hready = hreadyout;
	spsc_core u_dut (.*);
	spsc_far_end u_far (
		.sck_oe (serial_clock_pin_oe),
		.sdo    (serial_data_out_pin),
		.sdi    (serial_data_in_pin)
	);
	initial begin
		hclk = 1'h0;
		forever #2 hclk = ~hclk;
	end
	task automatic print_verdict();
		if (error_cnt == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict
	task automatic chk(input string s, input logic [31:0] v, input logic [31:0] e);
		n_checks++;
		if (v !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", s, e, v);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {20'h0_0000, a};
		do @(posedge hclk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		r = hrdata;
	endtask : bus
	task automatic rd(input string s, input logic [11:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0000_0000);
		chk(s, r, e);
	endtask : rd
	task automatic poll(input logic [31:0] m);
		do bus(1'h0, 12'h000, 32'h0000_0000); while ((r & m) == 32'h0000_0000);
	endtask : poll
	// Hang guard: about five transfers need a few thousand cycles
	always @(posedge hclk) begin
		cyc++;
		if (cyc > 20000) begin
			error_cnt++;
			print_verdict();
		end
	end
	initial begin
		{hresetn, hsel, hwrite, device_idle, serial_clock_pin_in} = '0;
		slave_select_pin_n = 1'h1;
		hsize = 3'h2;
		htrans = 2'h0;
		haddr = '0;
		hwdata = '0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'h1;
		hsel <= 1'h1;
		@(posedge hclk);
		rd("stat", 12'h000, 32'h0000_0000);
		rd("unmapped", 12'h020, 32'h0000_0000);
		bus(1'h1, 12'h004, 32'h0000_a5c3);
		rd("tbf", 12'h000, 32'h0000_0002);
		bus(1'h1, 12'h010, 32'h0000_0001);
		bus(1'h1, 12'h008, 32'h0000_0005);
		bus(1'h1, 12'h000, 32'h0000_8000);
		// Pin enables are registered one edge after the write lands
		@(posedge hclk);
		@(negedge hclk);
		chk("oe_on", {30'h0000_0000, serial_clock_pin_oe, serial_data_out_pin_oe}, 32'h0000_0003);
		@(posedge hclk);
		poll(32'h0000_0001);
		chk("rbf", r, 32'h0000_8001);
		chk("irq_on", {31'h0000_0000, irq}, 32'h0000_0001);
		bus(1'h1, 12'h00c, 32'h0000_0007);
		rd("rxb", 12'h004, 32'h0000_a5c3);
		rd("rbf_clr", 12'h000, 32'h0000_8000);
		chk("irq_off", {31'h0000_0000, irq}, 32'h0000_0000);
		bus(1'h1, 12'h004, 32'h0000_1234);
		poll(32'h0000_0001);
		bus(1'h1, 12'h004, 32'h0000_5678);
		poll(32'h0000_0040);
		chk("rov", r, 32'h0000_8041);
		rd("kept", 12'h004, 32'h0000_1234);
		bus(1'h1, 12'h000, 32'h0000_8000);
		rd("rov_clr", 12'h000, 32'h0000_8000);
		// Halted transfer must not complete until idle ends
		bus(1'h1, 12'h000, 32'h0000_a000);
		device_idle <= 1'h1;
		bus(1'h1, 12'h004, 32'h0000_0ff0);
		repeat (600) @(posedge hclk);
		bus(1'h0, 12'h000, 32'h0000_0000);
		chk("halt", {31'h0000_0000, r[0]}, 32'h0000_0000);
		device_idle <= 1'h0;
		poll(32'h0000_0001);
		rd("resume", 12'h004, 32'h0000_0ff0);
		// Byte mode with inverted clock polarity
		bus(1'h1, 12'h008, 32'h0000_0006);
		bus(1'h1, 12'h004, 32'h0000_12a5);
		poll(32'h0000_0001);
		rd("byte", 12'h004, 32'h0000_00a5);
		bus(1'h1, 12'h000, 32'h0000_0000);
		repeat (4) @(posedge hclk);
		chk("oe_off", {30'h0000_0000, serial_clock_pin_oe, serial_data_out_pin_oe}, 32'h0000_0000);
		print_verdict();
	end
endmodule : serial_port_status_control_tb_top
